/* src/coe_pkg.sv */
// Shared constants, settings layout and state codes for the output extras.
package coe_pkg;

  // Clock and timing.
  localparam int CLK_HZ       = 20_000_000;
  localparam int CLK_NS       = 1_000_000_000 / CLK_HZ;
  localparam int MS_NS        = 1_000_000;
  localparam int TICK_CYC_DEF = MS_NS / CLK_NS;

  // Filter half periods in ns and the stable sample counts derived from them.
  localparam int FLT_50K_NS   = 10_000;
  localparam int FLT_500K_NS  = 1_000;
  localparam int FLT_10K_NS   = 50_000;
  localparam int FLT_W        = 10;
  localparam logic [FLT_W-1:0] FLT_50K_CYC  = FLT_W'(FLT_50K_NS / CLK_NS);
  localparam logic [FLT_W-1:0] FLT_500K_CYC = FLT_W'(FLT_500K_NS / CLK_NS);
  localparam logic [FLT_W-1:0] FLT_10K_CYC  = FLT_W'(FLT_10K_NS / CLK_NS);

  // Filter select codes.
  localparam logic [1:0] ENC_FLT_50K  = 2'h0;
  localparam logic [1:0] ENC_FLT_500K = 2'h1;
  localparam logic [1:0] ENC_FLT_10K  = 2'h2;
  localparam logic       IN_FLT_50K   = 1'h0;
  localparam logic       IN_FLT_10K   = 1'h1;

  // Setting field limits and reset values.
  localparam int         TM_W      = 14;
  localparam int         HYS_W     = 8;
  localparam logic [7:0] HYS_MAX   = 8'hFF;
  localparam logic [3:0] BCD_MAX   = 4'h9;
  localparam logic [31:0] CNT_RST  = 32'h0000_0000;

  // Setting words transferred by the controller at restart.
  typedef struct packed {
    logic [15:0] output0_on_delay;
    logic [15:0] output0_pulse_length;
    logic [15:0] output1_on_delay;
    logic [15:0] output1_pulse_length;
    logic [15:0] counter1_hysteresis;
    logic [15:0] counter2_hysteresis;
    logic [15:0] encoder_filter_select;
    logic [15:0] input_filter_select;
    logic [31:0] counter1_start_value_linear;
    logic [31:0] counter2_start_value_linear;
    logic [31:0] counter1_start_value_circular;
    logic [31:0] counter2_start_value_circular;
  } coe_settings_s;

  // Per output timing state.
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_DELAY = 5'b00010,
    S_PULSE = 5'b00100,
    S_ON    = 5'b01000,
    S_HELD  = 5'b10000
  } coe_out_state_e;

endpackage

/* src/coe_noise_filter.sv */
// Glitch filter that accepts a new level only after it stays stable.
`timescale 1ns/1ps
module coe_noise_filter
  import coe_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             raw,
  input  wire logic [FLT_W-1:0] need,
  output logic                  filt
);

  logic [FLT_W-1:0] run_reg;
  logic [FLT_W-1:0] run_next;
  logic             filt_reg;
  logic             differs;
  logic             accept;

  // A changed level must hold for need samples before it passes.
  assign differs  = raw != filt_reg;
  assign accept   = differs && (run_reg >= need - FLT_W'(1));
  assign run_next = differs ? run_reg + FLT_W'(1) : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      run_reg  <= '0;
      filt_reg <= 1'b0;
    end else if (ce) begin
      run_reg  <= accept ? '0 : run_next;
      filt_reg <= accept ? raw : filt_reg;
    end
  end

  assign filt = filt_reg;

endmodule

/* src/coe_output_extras.sv */
// Output timing, hysteresis, noise filters and initial counts of two counters.
//
// Operation
// - Each output keeps a BCD turn-on delay in ms; zero means no delay.
// - Each output keeps a BCD pulse length in ms; zero means steady on.
// - Timing starts on pattern bit rise; delay first, then the pulse.
// - Pattern bit falling aborts any timing and turns the output off unless manual on is set.
// - Manual on drives the output at once, skipping delay and pulse.
// - After a pulse, internal state stays on, physical off, until cleared.
// - Each counter has a hysteresis band 0 to 255; zero disables it.
// - Count changes smaller than the band are not passed as changes.
// - Hysteresis acts only in range mode, never in comparison mode.
// - Shared encoder filter select: 0 is 50 kHz, 1 500 kHz, 2 10 kHz.
// - Shared input filter select: 0 is 50 kHz, 1 is 10 kHz.
// - Restart loads each counter with its initial value, replacing the count.
// - Linear and simple counters take a signed 32-bit initial value.
// - Circular counters take a separate unsigned 32-bit initial value.
`timescale 1ns/1ps
module coe_output_extras
  import coe_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC_DEF
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              restart,
  input  wire coe_settings_s     settings,
  input  wire logic [1:0]        circular,
  input  wire logic [1:0]        range_mode,
  input  wire logic [1:0]        enc_a,
  input  wire logic [1:0]        enc_b,
  input  wire logic [1:0]        din_raw,
  input  wire logic [1:0]        pattern,
  input  wire logic [1:0]        manual_on,
  output logic [1:0]             dout,
  output logic [1:0]             out_state,
  output logic [1:0]             din_filt,
  output logic [1:0][31:0]       count_val,
  output logic [1:0][31:0]       hyst_val
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  function automatic logic [TM_W-1:0] bcd_to_bin(input logic [15:0] b);
    logic [3:0]      d [4];
    logic [TM_W-1:0] acc;
    acc = '0;
    for (int k = 3; k >= 0; k--) begin
      d[k] = (b[k*4 +: 4] > BCD_MAX) ? BCD_MAX : b[k*4 +: 4];
      acc  = TM_W'(acc * TM_W'(10)) + TM_W'(d[k]);
    end
    return acc;
  endfunction

  function automatic logic [HYS_W-1:0] clamp_band(input logic [15:0] v);
    return (v > 16'(HYS_MAX)) ? HYS_MAX : v[HYS_W-1:0];
  endfunction

  // Quadrature step: bit 0 counts up, bit 1 counts down.
  function automatic logic [1:0] quad_step(input logic [1:0] p,
                                           input logic [1:0] c);
    logic [3:0] t;
    t = {p, c};
    case (t)
      4'h1, 4'h7, 4'hE, 4'h8: return 2'h1;
      4'h2, 4'hB, 4'hD, 4'h4: return 2'h2;
      default:                return 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Settings taken at restart.

  logic [1:0][15:0]       set_delay;
  logic [1:0][15:0]       set_pulse;
  logic [1:0][15:0]       set_band;
  logic [1:0][31:0]       set_lin;
  logic [1:0][31:0]       set_circ;
  logic [1:0][TM_W-1:0]   delay_reg;
  logic [1:0][TM_W-1:0]   pulse_reg;
  logic [1:0][HYS_W-1:0]  band_reg;
  logic [1:0]             enc_sel_reg;
  logic                   in_sel_reg;
  logic [FLT_W-1:0]       enc_need;
  logic [FLT_W-1:0]       in_need;

  assign set_delay = {settings.output1_on_delay,
                      settings.output0_on_delay};
  assign set_pulse = {settings.output1_pulse_length,
                      settings.output0_pulse_length};
  assign set_band  = {settings.counter2_hysteresis,
                      settings.counter1_hysteresis};
  assign set_lin   = {settings.counter2_start_value_linear,
                      settings.counter1_start_value_linear};
  assign set_circ  = {settings.counter2_start_value_circular,
                      settings.counter1_start_value_circular};

  always_ff @(posedge clk) begin
    if (rst) begin
      delay_reg   <= '0;
      pulse_reg   <= '0;
      band_reg    <= '0;
      enc_sel_reg <= ENC_FLT_50K;
      in_sel_reg  <= IN_FLT_50K;
    end else if (ce && restart) begin
      for (int i = 0; i < 2; i++) begin
        delay_reg[i] <= bcd_to_bin(set_delay[i]);
        pulse_reg[i] <= bcd_to_bin(set_pulse[i]);
        band_reg[i]  <= clamp_band(set_band[i]);
      end
      enc_sel_reg <= settings.encoder_filter_select[1:0];
      in_sel_reg  <= settings.input_filter_select[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Noise filters.

  assign enc_need = (enc_sel_reg == ENC_FLT_500K) ? FLT_500K_CYC :
                    (enc_sel_reg == ENC_FLT_10K)  ? FLT_10K_CYC  :
                    FLT_50K_CYC;
  assign in_need  = (in_sel_reg == IN_FLT_10K) ? FLT_10K_CYC : FLT_50K_CYC;

  logic [5:0] line_raw;
  logic [5:0] line_filt;

  assign line_raw = {din_raw, enc_b, enc_a};

  for (genvar g = 0; g < 6; g++) begin : g_flt
    coe_noise_filter u_flt (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .raw  (line_raw[g]),
      .need ((g < 4) ? enc_need : in_need),
      .filt (line_filt[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters and hysteresis.

  logic [1:0][1:0]  ab_prev_reg;
  logic [1:0][1:0]  ab_cur;
  logic [1:0][31:0] cnt_reg;
  logic [1:0][31:0] cnt_next;
  logic [1:0][31:0] hys_reg;
  logic [1:0][31:0] hys_next;
  logic [1:0][31:0] hys_diff;
  logic [1:0][31:0] hys_mag;
  logic [1:0]       hys_on;

  for (genvar c = 0; c < 2; c++) begin : g_cnt
    logic [1:0] step;
    assign ab_cur[c] = {line_filt[2+c], line_filt[c]};
    assign step      = quad_step(ab_prev_reg[c], ab_cur[c]);
    assign cnt_next[c] = restart     ? (circular[c] ? set_circ[c]
                                                    : set_lin[c]) :
                         step[0]     ? cnt_reg[c] + 32'h0000_0001 :
                         step[1]     ? cnt_reg[c] - 32'h0000_0001 :
                         cnt_reg[c];
    assign hys_on[c]   = range_mode[c] && (band_reg[c] != '0);
    assign hys_diff[c] = cnt_next[c] - hys_reg[c];
    assign hys_mag[c]  = hys_diff[c][31] ? (~hys_diff[c] + 32'h0000_0001)
                                         : hys_diff[c];
    // small swings do not move the held value.
    assign hys_next[c] = (!hys_on[c] || restart ||
                          hys_mag[c] >= 32'(band_reg[c])) ?
                         cnt_next[c] : hys_reg[c];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ab_prev_reg <= '0;
      cnt_reg     <= {2{CNT_RST}};
      hys_reg     <= {2{CNT_RST}};
    end else if (ce) begin
      ab_prev_reg <= ab_cur;
      cnt_reg     <= cnt_next;
      hys_reg     <= hys_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick.

  logic [TW-1:0] tick_cnt_reg;
  logic          tick_reg;
  logic          tick_wrap;

  assign tick_wrap = tick_cnt_reg == TW'(TICK_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (ce) begin
      tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + TW'(1);
      tick_reg     <= tick_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output timing.

  coe_out_state_e       st_reg  [2];
  coe_out_state_e       st_next [2];
  logic [1:0][TM_W-1:0] tm_reg;
  logic [1:0][TM_W-1:0] tm_next;
  logic [1:0]           pat_prev_reg;
  logic [1:0]           rise;
  logic [1:0]           dout_reg;
  logic [1:0]           dout_next;
  logic [1:0]           ost_reg;
  logic [1:0]           ost_next;

  assign rise = pattern & ~pat_prev_reg;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      st_next[i] = st_reg[i];
      tm_next[i] = tm_reg[i];
      if (!pattern[i]) begin
        st_next[i] = S_IDLE;
        tm_next[i] = '0;
      end else begin
        case (st_reg[i])
          S_IDLE: begin
            if (rise[i] && delay_reg[i] != '0) begin
              st_next[i] = S_DELAY;
              tm_next[i] = delay_reg[i];
            end else if (rise[i] && pulse_reg[i] != '0) begin
              st_next[i] = S_PULSE;
              tm_next[i] = pulse_reg[i];
            end else if (rise[i]) begin
              st_next[i] = S_ON;
            end
          end
          S_DELAY: begin
            if (tick_reg && tm_reg[i] == TM_W'(1)) begin
              st_next[i] = (pulse_reg[i] != '0) ? S_PULSE : S_ON;
              tm_next[i] = pulse_reg[i];
            end else if (tick_reg) begin
              tm_next[i] = tm_reg[i] - TM_W'(1);
            end
          end
          S_PULSE: begin
            if (tick_reg && tm_reg[i] == TM_W'(1)) begin
              st_next[i] = S_HELD;
              tm_next[i] = '0;
            end else if (tick_reg) begin
              tm_next[i] = tm_reg[i] - TM_W'(1);
            end
          end
          S_ON:    st_next[i] = S_ON;
          S_HELD:  st_next[i] = S_HELD;
          default: st_next[i] = S_IDLE;
        endcase
      end
      dout_next[i] = manual_on[i] || st_next[i] == S_ON ||
                     st_next[i] == S_PULSE;
      ost_next[i]  = manual_on[i] || st_next[i] == S_ON ||
                     st_next[i] == S_PULSE || st_next[i] == S_HELD;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg       <= '{S_IDLE, S_IDLE};
      tm_reg       <= '0;
      pat_prev_reg <= '0;
      dout_reg     <= '0;
      ost_reg      <= '0;
    end else if (ce) begin
      st_reg       <= st_next;
      tm_reg       <= tm_next;
      pat_prev_reg <= pattern;
      dout_reg     <= dout_next;
      ost_reg      <= ost_next;
    end
  end

  assign dout      = dout_reg;
  assign out_state = ost_reg;
  assign din_filt  = line_filt[5:4];
  assign count_val = cnt_reg;
  assign hyst_val  = hys_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tick_single: assert property (
    ce && tick_reg |=> !tick_reg)
    else $error("Millisecond tick lasted more than one cycle.");

  a_restart_load: assert property (
    ce && restart |=> cnt_reg[0] == ($past(circular[0]) ?
      $past(set_circ[0]) : $past(set_lin[0])))
    else $error("Counter did not take its initial value.");

  a_enc_filter_code: assert property (
    ce && restart && settings.encoder_filter_select[1:0] == ENC_FLT_10K
    |=> enc_need == FLT_10K_CYC)
    else $error("Encoder filter code not applied.");

  a_in_filter_code: assert property (
    ce && restart && settings.input_filter_select[0] == IN_FLT_10K
    |=> in_need == FLT_10K_CYC)
    else $error("Input filter code not applied.");

  a_hyst_bypass: assert property (
    ce && !range_mode[1] |=> hys_reg[1] == $past(cnt_next[1]))
    else $error("Held count lagged outside range mode.");

  sequence s_rise_plain(i);
    ce && rise[i] && !manual_on[i] && delay_reg[i] == '0;
  endsequence

  for (genvar i = 0; i < 2; i++) begin : g_chk
    a_fall_forces_off: assert property (
      ce && !pattern[i] && !manual_on[i] |=> !dout_reg[i] && !ost_reg[i])
      else $error("Output stayed on after pattern fell.");

    a_manual_immediate: assert property (
      ce && manual_on[i] |=> dout_reg[i])
      else $error("Manual on did not drive output.");

    a_plain_on: assert property (
      s_rise_plain(i) |=> dout_reg[i])
      else $error("Output did not turn on at pattern rise.");

    a_delay_waits: assert property (
      ce && rise[i] && !manual_on[i] && delay_reg[i] != '0
      |=> !dout_reg[i] && st_reg[i] == S_DELAY)
      else $error("Delayed output turned on too early.");

    a_pulse_held: assert property (
      ce && st_reg[i] == S_HELD && pattern[i] && !manual_on[i]
      |=> ost_reg[i] && !dout_reg[i])
      else $error("Expired pulse lost internal state or drove pin.");
  end

endmodule

/* testbench/coe_cpu_model.sv */
// Controller model that writes the setting words at restart.
`timescale 1ns/1ps
module coe_cpu_model
  import coe_pkg::*;
(
  input  wire logic     clk,
  output coe_settings_s settings,
  output logic          restart
);
  initial begin
    restart  = 1'b0;
    settings = '0;
  end

  task automatic load(input coe_settings_s s);
    restart  = 1'b1;
    settings = s;
    @(negedge clk);
    restart  = 1'b0;
    settings = ~s;
    @(negedge clk);
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the output extras block.
`timescale 1ns/1ps
module tb;
  import coe_pkg::*;
  localparam int TK = 10;
  logic             clk;
  logic             rst;
  logic             ce;
  logic             restart;
  coe_settings_s    settings;
  coe_settings_s    cfg;
  logic [1:0]       circular;
  logic [1:0]       range_mode;
  logic [1:0]       enc_a;
  logic [1:0]       enc_b;
  logic [1:0]       din_raw;
  logic [1:0]       pattern;
  logic [1:0]       manual_on;
  logic [1:0]       dout;
  logic [1:0]       out_state;
  logic [1:0]       din_filt;
  logic [1:0]       lv;
  logic [1:0][31:0] count_val;
  logic [1:0][31:0] hyst_val;
  logic [1:0]       g [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  int               p;
  int               err_total;
  int               cmp_count;
  int               nd [3] = '{200, 20, 1000};
  int               ni [2] = '{200, 1000};

  coe_cpu_model u_coe_cpu_model (
    .clk      (clk),
    .settings (settings),
    .restart  (restart)
  );

  coe_output_extras #(.TICK_CYCLES(TK)) u_coe_output_extras (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .restart    (restart),
    .settings   (settings),
    .circular   (circular),
    .range_mode (range_mode),
    .enc_a      (enc_a),
    .enc_b      (enc_b),
    .din_raw    (din_raw),
    .pattern    (pattern),
    .manual_on  (manual_on),
    .dout       (dout),
    .out_state  (out_state),
    .din_filt   (din_filt),
    .count_val  (count_val),
    .hyst_val   (hyst_val)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task chk(input logic [31:0] gv, input logic [31:0] ev);
    cmp_count++;
    if (gv !== ev) begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask

  task wt(input int i, input logic v, input int mx);
    int k;
    k = 0;
    while (dout[i] !== v && k < mx) begin
      cyc(1);
      k++;
    end
  endtask

  task mv(input int d, input int w);
    p = (p + d) % 4;
    {enc_a[0], enc_b[0]} = g[p];
    cyc(w);
  endtask

  task finish_test;
    $display("err_total=%0d cmp_count=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cfg = '0;
    {circular, range_mode, enc_a, enc_b} = 8'h00;
    {din_raw, pattern, manual_on} = 6'h00;
    err_total = 0;
    cmp_count = 0;
    p = 0;
    cyc(12);
    rst = 1'b0;
    cyc(1);
    // Start values of both counter kinds.
    cfg.counter1_start_value_linear = 32'h8000_0000;
    cfg.counter2_start_value_linear = 32'h7FFF_FFFF;
    cfg.counter2_start_value_circular = 32'hFFFF_FFFF;
    cfg.counter1_start_value_circular = 32'h0000_0001;
    circular = 2'h2;
    u_coe_cpu_model.load(cfg);
    chk(count_val[0], 32'h8000_0000);
    chk(count_val[1], 32'hFFFF_FFFF);
    circular = 2'h1;
    u_coe_cpu_model.load(cfg);
    chk(count_val[0], 32'h0000_0001);
    chk(count_val[1], 32'h7FFF_FFFF);
    $display("done start values");
    // Plain output, then delayed, aborted and manual.
    pattern[0] = 1'b1;
    cyc(1);
    chk(dout[0], 1'b1);
    pattern[0] = 1'b0;
    cyc(1);
    chk(dout[0], 1'b0);
    cfg.output0_on_delay = 16'h0012;
    u_coe_cpu_model.load(cfg);
    pattern[0] = 1'b1;
    cyc(100);
    chk(dout[0], 1'b0);
    wt(0, 1'b1, 30);
    chk(dout[0], 1'b1);
    pattern[0] = 1'b0;
    cyc(1);
    pattern[0] = 1'b1;
    cyc(60);
    pattern[0] = 1'b0;
    cyc(1);
    chk(dout[0], 1'b0);
    pattern[0] = 1'b1;
    cyc(100);
    chk(dout[0], 1'b0);
    manual_on[0] = 1'b1;
    cyc(1);
    chk(dout[0], 1'b1);
    manual_on[0] = 1'b0;
    pattern[0] = 1'b0;
    cyc(1);
    $display("done delay");
    // Pulse on output 1 and the held state after it.
    cfg.output1_pulse_length = 16'h0002;
    u_coe_cpu_model.load(cfg);
    pattern[1] = 1'b1;
    cyc(1);
    chk(dout[1], 1'b1);
    cyc(8);
    chk(dout[1], 1'b1);
    wt(1, 1'b0, 14);
    chk(dout[1], 1'b0);
    cyc(30);
    chk({dout[1], out_state[1]}, 2'h1);
    pattern[1] = 1'b0;
    cyc(1);
    chk(out_state[1], 1'b0);
    $display("done pulse");
    // Encoder filter codes.
    circular = 2'h0;
    cfg.counter1_start_value_linear = 32'h0000_0010;
    for (int c = 0; c < 3; c++) begin
      cfg.encoder_filter_select = 16'(c);
      u_coe_cpu_model.load(cfg);
      mv(1, nd[c] * 3 / 4);
      chk(count_val[0], 32'h0000_0010);
      cyc(nd[c] / 4 + 5);
      chk(count_val[0], 32'h0000_0011);
    end
    // Digital input filter codes.
    for (int c = 0; c < 2; c++) begin
      cfg.input_filter_select = 16'(c);
      u_coe_cpu_model.load(cfg);
      lv = din_raw;
      din_raw = ~din_raw;
      cyc(ni[c] * 3 / 4);
      chk(din_filt, lv);
      cyc(ni[c] / 4 + 5);
      chk(din_filt, din_raw);
    end
    $display("done filters");
    // Hysteresis band in range mode, none in comparison mode.
    cfg.encoder_filter_select = 16'h0001;
    cfg.counter1_hysteresis = 16'h0003;
    cfg.counter1_start_value_linear = 32'h0000_0100;
    range_mode = 2'h1;
    u_coe_cpu_model.load(cfg);
    mv(1, 25);
    chk(count_val[0], 32'h0000_0101);
    chk(hyst_val[0], 32'h0000_0100);
    mv(3, 25);
    mv(1, 25);
    mv(1, 25);
    chk(hyst_val[0], 32'h0000_0100);
    mv(1, 25);
    chk(hyst_val[0], 32'h0000_0103);
    range_mode = 2'h0;
    mv(1, 25);
    chk(hyst_val[0], 32'h0000_0104);
    $display("done hysteresis");
    // Clock enable low freezes the filters and the counters.
    ce = 1'b0;
    mv(1, 25);
    chk(count_val[0], 32'h0000_0104);
    ce = 1'b1;
    cyc(25);
    chk(count_val[0], 32'h0000_0105);
    $display("done clock enable");
    finish_test;
  end
endmodule
